// [pkg/tao_pkg.sv]
`default_nettype none
package tao_pkg;
  // Opcodes
  localparam logic [7:0] TABLE_OPC = 8'h48;
  localparam logic [7:0] ADD_PREFIX = 8'h60;
  // Second byte: bit 7 chooses the accumulator as destination,
  // bits 6..3 choose the operation, bits 2..0 the operand register
  localparam int DIR_BIT = 7;
  localparam int OP_MSB = 6;
  localparam int OP_LSB = 3;
  localparam int SEL_MSB = 2;
  localparam logic [3:0] OP_PLAIN = 4'h8;
  localparam logic [3:0] OP_CARRY = 4'hA;
  localparam logic [3:0] OP_SKIP_NC = 4'h4;
  // Operand register indices
  localparam logic [2:0] IDX_PAGE_HIGH = 3'h0;
  localparam logic [2:0] IDX_ACC = 3'h1;
  localparam logic [2:0] IDX_PAIR1_HIGH = 3'h2;
  localparam logic [2:0] IDX_PAIR1_LOW = 3'h3;
  localparam logic [2:0] IDX_PAIR2_HIGH = 3'h4;
  localparam logic [2:0] IDX_PAIR2_LOW = 3'h5;
  localparam logic [2:0] IDX_PAIR3_HIGH = 3'h6;
  localparam logic [2:0] IDX_PAIR3_LOW = 3'h7;
  // Table base lies this far past the instruction's own address
  localparam logic [15:0] TABLE_PC_OFS = 16'h0003;
  // Instruction lengths in machine states, one state per CLK cycle
  localparam logic [4:0] TABLE_STATES = 5'h11;
  localparam logic [4:0] ADD_STATES = 5'h08;
  localparam logic [4:0] SKIP_STATES = 5'h04;
  // Table read schedule, as state counts
  localparam logic [4:0] TBL_RD_HI = 5'h00;
  localparam logic [4:0] TBL_CAP_LO = 5'h01;
  localparam logic [4:0] TBL_CAP_HI = 5'h02;
  // Flag load word layout
  localparam int FW_ZERO = 5;
  localparam int FW_SKIP = 4;
  localparam int FW_HALF = 3;
  localparam int FW_CHAIN_A = 2;
  localparam int FW_CHAIN_HL = 1;
  localparam int FW_CARRY = 0;
  // Reset values
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [15:0] ADDR_RESET = 16'h0000;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ADD = 2'b01,
    ST_TBL = 2'b11,
    ST_SKIP = 2'b10
  } tao_state_t;
endpackage : tao_pkg
`default_nettype wire

// [logic/tao_exec.sv]
// Operation
// RULE_01 - Table pick-up loads pair1 from PC+3+A low byte first and clears skip and chain flags.
// RULE_02 - Table pick-up is a two-byte instruction lasting 17 machine states.
// RULE_03 - All register add instructions begin with the common first byte 01100000.
// RULE_04 - The low three bits of the second byte pick one of eight operand registers.
// RULE_05 - Every register add form is two bytes long and lasts 8 machine states.
// RULE_06 - Plain add to A puts A plus register in A and sets flags, clearing skip and chains.
// RULE_07 - Plain add to a register stores register plus A there, flags as for the A form.
// RULE_08 - Add with carry to A stores register plus A plus carry in A and sets the flags.
// RULE_09 - Add with carry to a register stores register plus A plus carry in that register.
// RULE_10 - Skip-on-no-carry add to A stores the sum in A and sets skip when no carry came out.
// RULE_11 - Skip-on-no-carry add to a register stores the sum there, skipping on no carry.
// RULE_12 - Both skip-on-no-carry forms set the arithmetic flags and clear both chain flags.
// RULE_13 - Zero marks a zero result, half carry a carry from bit 3, carry a carry from bit 7.
// RULE_14 - With skip set, the next instruction is fetched and discarded, then skip clears.
`default_nettype none
module tao_exec
  import tao_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic START,
  input wire logic [7:0] OPC1,
  input wire logic [7:0] OPC2,
  input wire logic [15:0] PC,
  input wire logic LOAD_EN,
  input wire logic [2:0] LOAD_SEL,
  input wire logic [7:0] LOAD_DATA,
  input wire logic FLAG_WR,
  input wire logic [5:0] FLAG_WDATA,
  input wire logic [7:0] MEM_RDATA,
  output logic MEM_RD,
  output logic [15:0] MEM_ADDR,
  output logic BUSY,
  output logic DONE,
  output logic BAD_OP,
  output logic SKIPPED,
  output logic [7:0] REG_PAGE_HIGH,
  output logic [7:0] REG_ACC,
  output logic [7:0] REG_PAIR1_HIGH,
  output logic [7:0] REG_PAIR1_LOW,
  output logic [7:0] REG_PAIR2_HIGH,
  output logic [7:0] REG_PAIR2_LOW,
  output logic [7:0] REG_PAIR3_HIGH,
  output logic [7:0] REG_PAIR3_LOW,
  output logic ZERO_FLAG,
  output logic SKIP_FLAG,
  output logic HALF_CARRY_FLAG,
  output logic CARRY_FLAG,
  output logic CHAIN_A_FLAG,
  output logic CHAIN_HL_FLAG
);

  // Returns {half carry, carry, sum}
  function automatic logic [9:0] tao_add8(
    input logic [7:0] x,
    input logic [7:0] y,
    input logic cin
  );
    logic [4:0] lo;
    logic [8:0] full;
    lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, cin};
    full = {1'b0, x} + {1'b0, y} + {8'h00, cin};
    return {lo[4], full};
  endfunction : tao_add8

  tao_state_t state_q;
  logic [4:0] cnt_q;
  logic [7:0] regs_q [0:7];
  logic [3:0] op_q;
  logic to_acc_q;
  logic [2:0] sel_q;
  logic [7:0] tbl_lo_q;
  logic [7:0] tbl_hi_q;
  logic zero_q;
  logic skip_q;
  logic half_q;
  logic carry_q;
  logic chain_a_q;
  logic chain_hl_q;
  logic busy_q;
  logic done_q;
  logic bad_q;
  logic skipped_q;
  logic mem_rd_q;
  logic [15:0] mem_addr_q;

  logic idle_start;
  logic op_ok;
  logic add_end;
  logic tbl_end;
  logic skip_end;
  logic [7:0] operand;
  logic [9:0] add_res;
  logic [7:0] sum8;
  logic cin;

  assign idle_start = (state_q == ST_IDLE) && START;

  // Prefix and operation decode
  always_comb begin
    op_ok = 1'b0;
    if (OPC1 == ADD_PREFIX) begin
      if (OPC2[OP_MSB:OP_LSB] == OP_PLAIN) begin
        op_ok = 1'b1;
      end else if (OPC2[OP_MSB:OP_LSB] == OP_CARRY) begin
        op_ok = 1'b1;
      end else if (OPC2[OP_MSB:OP_LSB] == OP_SKIP_NC) begin
        op_ok = 1'b1;
      end
    end
  end

  // RULE_05 add length
  assign add_end = (state_q == ST_ADD) && (cnt_q == ADD_STATES - 5'h01);
  // RULE_02 table length
  assign tbl_end = (state_q == ST_TBL) && (cnt_q == TABLE_STATES - 5'h01);
  assign skip_end = (state_q == ST_SKIP) && (cnt_q == SKIP_STATES - 5'h01);

  // RULE_04 operand select
  assign operand = regs_q[sel_q];
  // RULE_08 carry input
  assign cin = (op_q == OP_CARRY) ? carry_q : 1'b0;
  // RULE_13 flag sources
  assign add_res = tao_add8(operand, regs_q[IDX_ACC], cin);
  assign sum8 = add_res[7:0];

  // Sequencer
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      state_q <= ST_IDLE;
      cnt_q <= 5'h00;
    end else begin
      case (state_q)
        ST_IDLE: begin
          cnt_q <= 5'h00;
          if (START) begin
            // RULE_14 discard next instruction
            if (skip_q) begin
              state_q <= ST_SKIP;
            end else if (OPC1 == TABLE_OPC) begin
              state_q <= ST_TBL;
            // RULE_03 common prefix
            end else if (op_ok) begin
              state_q <= ST_ADD;
            end
          end
        end
        ST_ADD: begin
          cnt_q <= cnt_q + 5'h01;
          if (add_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_TBL: begin
          cnt_q <= cnt_q + 5'h01;
          if (tbl_end) begin
            state_q <= ST_IDLE;
          end
        end
        ST_SKIP: begin
          cnt_q <= cnt_q + 5'h01;
          if (skip_end) begin
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Latched decode, so OPC2 need only be valid with START
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      op_q <= 4'h0;
      to_acc_q <= 1'b0;
      sel_q <= 3'h0;
    end else if (idle_start) begin
      op_q <= OPC2[OP_MSB:OP_LSB];
      to_acc_q <= OPC2[DIR_BIT];
      sel_q <= OPC2[SEL_MSB:0];
    end
  end

  // Table reads: one-cycle synchronous memory
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      mem_rd_q <= 1'b0;
      mem_addr_q <= ADDR_RESET;
      tbl_lo_q <= REG_RESET;
      tbl_hi_q <= REG_RESET;
    end else begin
      mem_rd_q <= 1'b0;
      if (idle_start && !skip_q && OPC1 == TABLE_OPC) begin
        // RULE_01 table address
        mem_rd_q <= 1'b1;
        mem_addr_q <= PC + TABLE_PC_OFS + {8'h00, regs_q[IDX_ACC]};
      end else if (state_q == ST_TBL && cnt_q == TBL_RD_HI) begin
        mem_rd_q <= 1'b1;
        mem_addr_q <= mem_addr_q + 16'h0001;
      end
      if (state_q == ST_TBL && cnt_q == TBL_CAP_LO) begin
        tbl_lo_q <= MEM_RDATA;
      end
      if (state_q == ST_TBL && cnt_q == TBL_CAP_HI) begin
        tbl_hi_q <= MEM_RDATA;
      end
    end
  end

  // Register file; results land on the last state so a stalled
  // instruction never leaves half-written state behind
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int i = 0; i < 8; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else if (add_end) begin
      // RULE_06 RULE_08 RULE_10 accumulator result
      if (to_acc_q) begin
        regs_q[IDX_ACC] <= sum8;
      // RULE_07 RULE_09 RULE_11 register result
      end else begin
        regs_q[sel_q] <= sum8;
      end
    end else if (tbl_end) begin
      // RULE_01 pair1 load
      regs_q[IDX_PAIR1_LOW] <= tbl_lo_q;
      regs_q[IDX_PAIR1_HIGH] <= tbl_hi_q;
    end else if (state_q == ST_IDLE && LOAD_EN) begin
      regs_q[LOAD_SEL] <= LOAD_DATA;
    end
  end

  // Flags
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      zero_q <= 1'b0;
      skip_q <= 1'b0;
      half_q <= 1'b0;
      carry_q <= 1'b0;
      chain_a_q <= 1'b0;
      chain_hl_q <= 1'b0;
    end else if (add_end) begin
      // RULE_13 arithmetic flags
      zero_q <= (sum8 == 8'h00);
      half_q <= add_res[9];
      carry_q <= add_res[8];
      // RULE_10 RULE_11 skip on no carry
      skip_q <= (op_q == OP_SKIP_NC) && !add_res[8];
      // RULE_06 RULE_12 chain flags
      chain_a_q <= 1'b0;
      chain_hl_q <= 1'b0;
    end else if (tbl_end) begin
      // RULE_01 flag clear
      skip_q <= 1'b0;
      chain_a_q <= 1'b0;
      chain_hl_q <= 1'b0;
    end else if (skip_end) begin
      // RULE_14 skip consumed
      skip_q <= 1'b0;
    end else if (state_q == ST_IDLE && !START && FLAG_WR) begin
      zero_q <= FLAG_WDATA[FW_ZERO];
      skip_q <= FLAG_WDATA[FW_SKIP];
      half_q <= FLAG_WDATA[FW_HALF];
      chain_a_q <= FLAG_WDATA[FW_CHAIN_A];
      chain_hl_q <= FLAG_WDATA[FW_CHAIN_HL];
      carry_q <= FLAG_WDATA[FW_CARRY];
    end
  end

  // Status
  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      bad_q <= 1'b0;
      skipped_q <= 1'b0;
    end else begin
      done_q <= add_end || tbl_end || skip_end;
      skipped_q <= skip_end;
      // Unknown opcodes retire at once and change nothing
      bad_q <= idle_start && !skip_q && OPC1 != TABLE_OPC && !op_ok;
      if (idle_start) begin
        busy_q <= skip_q || OPC1 == TABLE_OPC || op_ok;
      end else if (add_end || tbl_end || skip_end) begin
        busy_q <= 1'b0;
      end
    end
  end

  assign MEM_RD = mem_rd_q;
  assign MEM_ADDR = mem_addr_q;
  assign BUSY = busy_q;
  assign DONE = done_q;
  assign BAD_OP = bad_q;
  assign SKIPPED = skipped_q;
  assign REG_PAGE_HIGH = regs_q[IDX_PAGE_HIGH];
  assign REG_ACC = regs_q[IDX_ACC];
  assign REG_PAIR1_HIGH = regs_q[IDX_PAIR1_HIGH];
  assign REG_PAIR1_LOW = regs_q[IDX_PAIR1_LOW];
  assign REG_PAIR2_HIGH = regs_q[IDX_PAIR2_HIGH];
  assign REG_PAIR2_LOW = regs_q[IDX_PAIR2_LOW];
  assign REG_PAIR3_HIGH = regs_q[IDX_PAIR3_HIGH];
  assign REG_PAIR3_LOW = regs_q[IDX_PAIR3_LOW];
  assign ZERO_FLAG = zero_q;
  assign SKIP_FLAG = skip_q;
  assign HALF_CARRY_FLAG = half_q;
  assign CARRY_FLAG = carry_q;
  assign CHAIN_A_FLAG = chain_a_q;
  assign CHAIN_HL_FLAG = chain_hl_q;

endmodule : tao_exec
`default_nettype wire

// [verification/tao_exec_asserts.sv]
`default_nettype none
module tao_exec_asserts
  import tao_pkg::*;
(
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic START,
  input wire logic [7:0] OPC1,
  input wire logic [7:0] OPC2,
  input wire logic [15:0] PC,
  input wire logic MEM_RD,
  input wire logic [15:0] MEM_ADDR,
  input wire logic BUSY,
  input wire logic DONE,
  input wire logic BAD_OP,
  input wire logic SKIPPED,
  input wire logic [7:0] REG_ACC,
  input wire logic ZERO_FLAG,
  input wire logic SKIP_FLAG,
  input wire logic CARRY_FLAG,
  input wire logic CHAIN_A_FLAG,
  input wire logic CHAIN_HL_FLAG
);
  logic go;
  logic tbl;
  logic ad;
  logic [3:0] op;
  logic chn;
  assign go = START && !BUSY && !SKIP_FLAG;
  assign tbl = go && OPC1 == TABLE_OPC;
  assign op = OPC2[OP_MSB:OP_LSB];
  assign ad = go && OPC1 == ADD_PREFIX && op inside {OP_PLAIN, OP_CARRY, OP_SKIP_NC};
  assign chn = CHAIN_A_FLAG || CHAIN_HL_FLAG;
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (!RSTN);
  tbl_len_a: assert property (tbl |-> ##18 (DONE && !BUSY))
    else $error("table retire time wrong");
  tbl_addr_a: assert property (tbl |=> (MEM_RD && MEM_ADDR == $past(PC) + TABLE_PC_OFS
    + 16'($past(REG_ACC))) ##1 (MEM_RD && MEM_ADDR == $past(MEM_ADDR) + 16'h0001))
    else $error("table read address wrong");
  tbl_flags_a: assert property (tbl |-> ##18 !(SKIP_FLAG || chn))
    else $error("table flags not cleared");
  add_len_a: assert property (ad |=> (BUSY && !DONE) [*8] ##1 (DONE && !BUSY))
    else $error("add retire time wrong");
  skip_nc_a: assert property (ad && op == OP_SKIP_NC |->
    ##9 (SKIP_FLAG != CARRY_FLAG && !chn))
    else $error("skip flag not inverse of carry");
  plain_clr_a: assert property (ad && op != OP_SKIP_NC |-> ##9 !(SKIP_FLAG || chn))
    else $error("add did not clear skip or chain");
  zero_flag_a: assert property (ad && OPC2[DIR_BIT] |->
    ##9 ZERO_FLAG == (REG_ACC == 8'h00))
    else $error("zero flag wrong");
  skip_disc_a: assert property (START && !BUSY && SKIP_FLAG |->
    ##5 (DONE && SKIPPED && !SKIP_FLAG))
    else $error("discard wrong");
  bad_op_a: assert property (go && OPC1 != TABLE_OPC && OPC1 != ADD_PREFIX |=>
    BAD_OP && !DONE)
    else $error("foreign opcode not refused");
endmodule : tao_exec_asserts

bind tao_exec tao_exec_asserts u_chk (.CLK, .RSTN, .START, .OPC1, .OPC2, .PC, .MEM_RD,
  .MEM_ADDR, .BUSY, .DONE, .BAD_OP, .SKIPPED, .REG_ACC, .ZERO_FLAG, .SKIP_FLAG, .CARRY_FLAG,
  .CHAIN_A_FLAG, .CHAIN_HL_FLAG);
`default_nettype wire

// [verification/tb_tao_exec.sv]
`default_nettype none
module tb_tao_exec
  import tao_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic CLK = '0;
  logic RSTN = '0;
  logic START = '0;
  logic LOAD_EN = '0;
  logic FLAG_WR = '0;
  logic [7:0] OPC1 = '0;
  logic [7:0] OPC2 = '0;
  logic [7:0] LOAD_DATA = '0;
  logic [7:0] MEM_RDATA = '0;
  logic [15:0] PC = '0;
  logic [2:0] LOAD_SEL = '0;
  logic [5:0] FLAG_WDATA = '0;
  logic MEM_RD, BUSY, DONE, BAD_OP, SKIPPED;
  logic ZERO_FLAG, SKIP_FLAG, HALF_CARRY_FLAG, CARRY_FLAG, CHAIN_A_FLAG, CHAIN_HL_FLAG;
  logic [15:0] MEM_ADDR;
  logic [7:0] rg [8];
  logic [5:0] flg;
  int error_cnt = 0;
  int cmp_count = 0;
  assign flg = {ZERO_FLAG, SKIP_FLAG, HALF_CARRY_FLAG, CHAIN_A_FLAG, CHAIN_HL_FLAG, CARRY_FLAG};

  tao_exec u_dut (.CLK, .RSTN, .START, .OPC1, .OPC2, .PC, .LOAD_EN, .LOAD_SEL, .LOAD_DATA,
    .FLAG_WR, .FLAG_WDATA, .MEM_RDATA, .MEM_RD, .MEM_ADDR, .BUSY, .DONE, .BAD_OP, .SKIPPED,
    .REG_PAGE_HIGH(rg[0]), .REG_ACC(rg[1]), .REG_PAIR1_HIGH(rg[2]), .REG_PAIR1_LOW(rg[3]),
    .REG_PAIR2_HIGH(rg[4]), .REG_PAIR2_LOW(rg[5]), .REG_PAIR3_HIGH(rg[6]),
    .REG_PAIR3_LOW(rg[7]), .ZERO_FLAG, .SKIP_FLAG, .HALF_CARRY_FLAG, .CARRY_FLAG,
    .CHAIN_A_FLAG, .CHAIN_HL_FLAG);

  initial begin
    forever #25 CLK = ~CLK;
  end

  // Memory stand-in: data is a function of address; junk when not reading
  always @(posedge CLK) begin
    MEM_RDATA <= #1 MEM_RD ? MEM_ADDR[7:0] ^ 8'h5A : ~MEM_RDATA;
  end

  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    cmp_count++;
    if (s !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  task automatic load(input logic [2:0] s, input logic [7:0] d);
    LOAD_EN = 1'h1;
    LOAD_SEL = s;
    LOAD_DATA = d;
    @(posedge CLK);
    #1 LOAD_EN = 1'h0;
    // Idle edge, so a following load never re-raises the strobe in the same step
    @(posedge CLK);
    #1;
  endtask : load

  task automatic setf(input logic [5:0] f);
    FLAG_WR = 1'h1;
    FLAG_WDATA = f;
    @(posedge CLK);
    #1 FLAG_WR = 1'h0;
  endtask : setf

  // Counts states from the taking edge to DONE or BAD_OP
  task automatic issue(input logic [7:0] o1, input logic [7:0] o2, input logic [15:0] p,
    output logic [4:0] n, output logic sk);
    START = 1'h1;
    OPC1 = o1;
    OPC2 = o2;
    PC = p;
    @(posedge CLK);
    #1 START = 1'h0;
    n = 5'h00;
    while (DONE !== 1'h1 && BAD_OP !== 1'h1) begin
      @(posedge CLK);
      #1 n++;
      if (n > 5'h19) begin
        error_cnt++;
        complete_run();
      end
    end
    sk = SKIPPED;
  endtask : issue

  task automatic t_table;
    logic [4:0] n;
    logic sk;
    logic [15:0] a;
    load(IDX_ACC, 8'hFE);
    setf(6'h06);
    issue(TABLE_OPC, 8'h00, 16'h12F0, n, sk);
    a = 16'h12F0 + 16'h0003 + 16'h00FE;
    chk(16'(n), 16'h0011);
    chk(16'(rg[IDX_PAIR1_LOW]), 16'(a[7:0] ^ 8'h5A));
    chk(16'(rg[IDX_PAIR1_HIGH]), 16'((a[7:0] + 8'h01) ^ 8'h5A));
    chk(16'(flg[4:1]), 16'h0000);
    $display("t_table done");
  endtask : t_table

  task automatic t_add(input logic [7:0] o2, input logic [7:0] a, input logic [7:0] r,
    input logic cf);
    logic [4:0] n;
    logic sk;
    logic ci;
    logic [8:0] s;
    logic [5:0] f;
    ci = (o2[6:3] == OP_CARRY) & cf;
    s = {1'h0, a} + {1'h0, r} + 9'(ci);
    f = {s[7:0] == 8'h00, (o2[6:3] == OP_SKIP_NC) & ~s[8],
      ({1'h0, a[3:0]} + {1'h0, r[3:0]} + 5'(ci)) > 5'h0F, 2'h0, s[8]};
    load(IDX_ACC, a);
    load(IDX_PAIR1_LOW, r);
    setf({5'h03, cf});
    issue(ADD_PREFIX, o2, 16'h0000, n, sk);
    chk(16'(n), 16'h0008);
    chk(16'(o2[7] ? rg[IDX_ACC] : rg[IDX_PAIR1_LOW]), 16'(s[7:0]));
    chk(16'(o2[7] ? rg[IDX_PAIR1_LOW] : rg[IDX_ACC]), 16'(o2[7] ? r : a));
    chk(16'(flg), 16'(f));
    if (f[4]) begin
      issue(ADD_PREFIX, 8'hC3, 16'h0000, n, sk);
      chk(16'({n, sk, SKIP_FLAG}), 16'({5'h04, 2'h2}));
      chk(16'(rg[IDX_ACC]), 16'(o2[7] ? s[7:0] : a));
    end
  endtask : t_add

  task automatic t_adds;
    t_add(8'hC3, 8'h8F, 8'h71, 1'h0);
    t_add(8'h43, 8'h12, 8'h34, 1'h1);
    t_add(8'hD3, 8'hFF, 8'h00, 1'h1);
    t_add(8'h53, 8'h27, 8'h18, 1'h1);
    t_add(8'hA3, 8'h01, 8'h02, 1'h0);
    t_add(8'hA3, 8'hF0, 8'h20, 1'h0);
    t_add(8'h23, 8'h05, 8'h06, 1'h0);
    $display("t_adds done");
  endtask : t_adds

  task automatic t_select;
    logic [4:0] n;
    logic sk;
    for (int i = 0; i < 8; i++) begin
      load(3'(i), 8'h10 + 8'(i));
      load(IDX_ACC, 8'h01);
      issue(ADD_PREFIX, {5'h18, 3'(i)}, 16'h0000, n, sk);
      chk(16'(rg[IDX_ACC]), (i == 1) ? 16'h0002 : 16'h0011 + 16'(i));
    end
    $display("t_select done");
  endtask : t_select

  task automatic t_bad;
    logic [4:0] n;
    logic sk;
    load(IDX_ACC, 8'h3C);
    issue(8'h61, 8'hC3, 16'h0000, n, sk);
    chk(16'({n, BAD_OP, DONE}), 16'({5'h00, 2'h2}));
    // Refusal retires at once; let an edge pass before START rises again
    @(posedge CLK);
    #1;
    issue(ADD_PREFIX, 8'hF3, 16'h0000, n, sk);
    chk(16'({rg[IDX_ACC], BAD_OP}), 16'({8'h3C, 1'h1}));
    $display("t_bad done");
  endtask : t_bad

  initial begin
    repeat (6) @(posedge CLK);
    #1 RSTN = 1'h1;
    t_table();
    t_adds();
    t_select();
    t_bad();
    complete_run();
  end
endmodule : tb_tao_exec
`default_nettype wire
